// File: pirq_consts.svh
// Purpose: offsets, field positions, reset values and counts for pirq
// Assumes: 32-bit APB, one word per register
// Notes: included by bare name
//
// What this block does
// - four priority levels for all requests
// - thirteen sources, each with own vector
// - private enable bit per source, two registers
// - global enable bit blocks every source
// - two priority bits per source, high/low
// - preempt only by strictly higher level
// - top level service blocks all vectoring
// - higher level wins among simultaneous requests
// - equal levels resolved by fixed polling order
// - fixed rank order of the thirteen sources
// - fixed vectors, eight byte steps from 0003h
// - serial tx/rx share line, enable, vector
// - listed sources wake core from power-down
// - level mode flag follows low pin
// - edge mode flag set on high-then-low samples
// - edge flag cleared when core vectors
// - bus request is OR of attention flags
`ifndef PIRQ_CONSTS_SVH
`define PIRQ_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PIRQ_OFF_EN_A 8'h00
`define PIRQ_OFF_EN_B 8'h04
`define PIRQ_OFF_PLO_A 8'h08
`define PIRQ_OFF_PHI_A 8'h0C
`define PIRQ_OFF_PLO_B 8'h10
`define PIRQ_OFF_PHI_B 8'h14
`define PIRQ_OFF_TRIG 8'h18
`define PIRQ_OFF_STATE 8'h1C
`define PIRQ_OFF_VECT 8'h20
`define PIRQ_OFF_EVT_ST 8'h24
`define PIRQ_OFF_EVT_CLR 8'h28
`define PIRQ_OFF_EVT_EN 8'h2C

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PIRQ_GLOBAL_BIT 7
`define PIRQ_REG_RESET 8'h00
`define PIRQ_SLOT_MASK 16'hB77F
`define PIRQ_WAKE_MASK 16'h3665
`define PIRQ_NUM_SRC 13
`define PIRQ_NUM_LEVELS 4
// slots in rank order, first rank in the low nibble
`define PIRQ_RANK_ORDER 52'hF_4A3D_92C8_1650
// vector step index per slot, slot 0 in the low nibble
`define PIRQ_VEC_INDEX 64'hE0CB_0876_0A54_3210
`define PIRQ_VEC_BASE 16'h0003
`define PIRQ_MC_CLOCKS 6
`define PIRQ_EVT_BITS 4

`endif

// File: pirq_pkg.sv
// Purpose: shared types of the interrupt controller
// Assumes: nothing
// Notes: slot n is bit n of {enable_reg_b, enable_reg_a}
package pirq_pkg;
	typedef logic [15:0] pirq_vec_t;
	typedef logic [1:0] pirq_level_t;
	typedef logic [3:0] pirq_slot_t;
endpackage : pirq_pkg

// File: pirq_arb_if.sv
// Purpose: carrier between controller and arbiter
// Assumes: combinational arbiter
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface pirq_arb_if;
	pirq_pkg::pirq_vec_t req;
	pirq_pkg::pirq_vec_t lvl_hi;
	pirq_pkg::pirq_vec_t lvl_lo;
	logic cur_active;
	pirq_pkg::pirq_level_t cur_level;
	logic win_valid;
	pirq_pkg::pirq_slot_t win_slot;
	pirq_pkg::pirq_level_t win_level;
	modport arb (input req, lvl_hi, lvl_lo, cur_active, cur_level,
		output win_valid, win_slot, win_level);
	modport ctl (output req, lvl_hi, lvl_lo, cur_active, cur_level,
		input win_valid, win_slot, win_level);
endinterface : pirq_arb_if
`default_nettype wire

// File: pirq_arbiter.sv
// Purpose: pick the winning request by level, then by rank
// Assumes: req already gated by enables
// Notes: purely combinational
`timescale 1ns/10ps
`include "pirq_consts.svh"
`default_nettype none
module pirq_arbiter (
	pirq_arb_if.arb a
);
	function automatic pirq_pkg::pirq_slot_t rank_slot(input int k);
		logic [51:0] order;
		order = `PIRQ_RANK_ORDER;
		rank_slot = order[k*4 +: 4];
	endfunction : rank_slot

	pirq_pkg::pirq_level_t max_lvl;
	pirq_pkg::pirq_level_t lvl;
	pirq_pkg::pirq_slot_t s;
	logic any;

	always_comb begin
		max_lvl = 2'b00;
		any = 1'b0;
		win_scan_init: begin
			a.win_slot = 4'h0;
		end
		// highest requested level first
		for (int i = 0; i < 16; i++) begin
			lvl = {a.lvl_hi[i], a.lvl_lo[i]};
			if (a.req[i] && (!any || lvl > max_lvl)) begin
				max_lvl = lvl;
				any = 1'b1;
			end
		end
		// walk ranks backwards so the first rank is written last
		for (int k = `PIRQ_NUM_SRC - 1; k >= 0; k--) begin
			s = rank_slot(k);
			lvl = {a.lvl_hi[s], a.lvl_lo[s]};
			if (a.req[s] && lvl == max_lvl) begin
				a.win_slot = s;
			end
		end
		a.win_level = max_lvl;
		// nothing at or below the active level may preempt
		a.win_valid = any && (!a.cur_active || max_lvl > a.cur_level);
	end
endmodule : pirq_arbiter
`default_nettype wire

// File: pirq_ctrl.sv
// Purpose: four-level prioritized interrupt controller, APB registers
// Assumes: core_ack and core_reti are one-cycle pulses on clock
// Notes: outputs are registered; pin inputs pass four flops
`timescale 1ns/10ps
`include "pirq_consts.svh"
`default_nettype none
module pirq_ctrl #(
	parameter int MC_CLOCKS = `PIRQ_MC_CLOCKS
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext0_pin_n,
	input wire logic ext1_pin_n,
	input wire logic timer_zero_overflow_flag,
	input wire logic timer_one_overflow_flag,
	input wire logic serial_tx_done_flag,
	input wire logic serial_rx_done_flag,
	input wire logic brownout_flag,
	input wire logic bus_data_ready_flag,
	input wire logic bus_arb_loss_flag,
	input wire logic bus_start_flag,
	input wire logic bus_stop_flag,
	input wire logic keypad_flag,
	input wire logic comparator_one_flag,
	input wire logic comparator_two_flag,
	input wire logic watchdog_overflow_flag,
	input wire logic converter_done_flag,
	input wire logic bus_timeout_flag,
	input wire logic core_ack,
	input wire logic core_reti,
	output logic irq_req,
	output logic [15:0] irq_vector,
	output logic [1:0] irq_level,
	output logic wake,
	output logic ext0_request_flag,
	output logic ext1_request_flag,
	output logic evt_irq
);
	generate
		if (MC_CLOCKS < 1 || MC_CLOCKS > 255) begin : g_bad_mc
			$error("pirq_ctrl: MC_CLOCKS must be 1..255");
		end
	endgenerate

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pin_raw;
	logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_filt_q;
	assign pin_raw = {ext1_pin_n, ext0_pin_n};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					pin_s1_q[g] <= 1'b1;
					pin_s2_q[g] <= 1'b1;
					pin_s3_q[g] <= 1'b1;
					pin_filt_q[g] <= 1'b1;
				end else begin
					pin_s1_q[g] <= pin_raw[g];
					pin_s2_q[g] <= pin_s1_q[g];
					pin_s3_q[g] <= pin_s2_q[g];
					// a change counts once two stages agree
					if (pin_s2_q[g] == pin_s3_q[g]) begin
						pin_filt_q[g] <= pin_s3_q[g];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	logic [7:0] mc_cnt_q, mc_cnt_d;
	logic mc_tick_q, mc_tick_d;
	logic [7:0] en_a_q, en_a_d, en_b_q, en_b_d;
	logic [7:0] plo_a_q, plo_a_d, phi_a_q, phi_a_d;
	logic [7:0] plo_b_q, plo_b_d, phi_b_q, phi_b_d;
	logic [1:0] trig_q, trig_d;
	logic [1:0] samp_q, samp_d;
	logic [1:0] xflag_q, xflag_d;
	pirq_pkg::pirq_vec_t req_q, req_d;
	logic [3:0] insvc_q, insvc_d;
	logic irq_req_q, irq_req_d;
	pirq_pkg::pirq_slot_t slot_q, slot_d;
	logic [15:0] vec_q, vec_d;
	pirq_pkg::pirq_level_t lvl_q, lvl_d;
	logic wake_q, wake_d;
	logic [3:0] evt_st_q, evt_st_d, evt_en_q, evt_en_d;
	logic evt_irq_q, evt_irq_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;

	pirq_arb_if arb_bus ();
	pirq_arbiter u_arb (
		.a(arb_bus)
	);

	function automatic logic [15:0] vector_of(input pirq_pkg::pirq_slot_t s);
		logic [63:0] tab;
		logic [3:0] idx;
		tab = `PIRQ_VEC_INDEX;
		idx = tab[s*4 +: 4];
		vector_of = `PIRQ_VEC_BASE + {9'h000, idx, 3'b000};
	endfunction : vector_of

	function automatic logic [2:0] top_level(input logic [3:0] m);
		// bit 2 flags "something in service", low bits give the level
		top_level = m[3] ? 3'b111 : m[2] ? 3'b110 : m[1] ? 3'b101 :
			m[0] ? 3'b100 : 3'b000;
	endfunction : top_level

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= `PIRQ_OFF_EVT_EN) && (a[1:0] == 2'b00);
	endfunction : mapped

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic [2:0] top;
	logic wr, rd;
	pirq_pkg::pirq_vec_t raw, enabled, en_all;
	logic [3:0] evt_set;
	logic [2:0] rtop;

	always_comb begin
		mc_cnt_d = mc_cnt_q;
		mc_tick_d = 1'b0;
		en_a_d = en_a_q;
		en_b_d = en_b_q;
		plo_a_d = plo_a_q;
		phi_a_d = phi_a_q;
		plo_b_d = plo_b_q;
		phi_b_d = phi_b_q;
		trig_d = trig_q;
		samp_d = samp_q;
		xflag_d = xflag_q;
		req_d = req_q;
		insvc_d = insvc_q;
		irq_req_d = irq_req_q;
		slot_d = slot_q;
		vec_d = vec_q;
		lvl_d = lvl_q;
		evt_st_d = evt_st_q;
		evt_en_d = evt_en_q;
		evt_set = 4'h0;
		rtop = 3'b000;
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		wr = psel && penable && pready_q && pwrite;
		rd = psel && penable && !pready_q && !pwrite;
		pready_d = psel && penable && !pready_q;

		// machine cycle divider
		if (mc_cnt_q == 8'(MC_CLOCKS - 1)) begin
			mc_cnt_d = 8'h00;
			mc_tick_d = 1'b1;
		end else begin
			mc_cnt_d = mc_cnt_q + 8'h01;
		end

		// external request flags
		if (mc_tick_q) begin
			samp_d = pin_filt_q;
		end
		for (int i = 0; i < 2; i++) begin
			if (!trig_q[i]) begin
				xflag_d[i] = !pin_filt_q[i];
			end else begin
				if (core_ack && irq_req_q && slot_q == 4'(2 * i)) begin
					xflag_d[i] = 1'b0;
				end
				if (mc_tick_q && samp_q[i] && !pin_filt_q[i]) begin
					xflag_d[i] = 1'b1;
				end
			end
		end

		// request lines by slot
		raw = 16'h0000;
		raw[0] = xflag_q[0];
		raw[1] = timer_zero_overflow_flag;
		raw[2] = xflag_q[1];
		raw[3] = timer_one_overflow_flag;
		raw[4] = serial_tx_done_flag || serial_rx_done_flag;
		raw[5] = brownout_flag;
		raw[6] = watchdog_overflow_flag;
		raw[8] = bus_data_ready_flag || bus_arb_loss_flag ||
			bus_start_flag || bus_stop_flag;
		raw[9] = keypad_flag;
		raw[10] = comparator_two_flag;
		raw[12] = converter_done_flag;
		raw[13] = comparator_one_flag;
		raw[15] = bus_timeout_flag;
		en_all = {en_b_q, en_a_q} & `PIRQ_SLOT_MASK;
		enabled = raw & en_all & {16{en_a_q[`PIRQ_GLOBAL_BIT]}};
		wake_d = |(enabled & `PIRQ_WAKE_MASK);
		if (mc_tick_q) begin
			req_d = enabled;
		end

		// in-service stack, release on return first
		if (core_reti) begin
			rtop = top_level(insvc_q);
			if (rtop[2]) begin
				insvc_d[rtop[1:0]] = 1'b0;
			end
			evt_set[1] = 1'b1;
		end
		if (core_ack && irq_req_q) begin
			insvc_d[lvl_q] = 1'b1;
			irq_req_d = 1'b0;
			evt_set[0] = 1'b1;
			evt_set[2] = |insvc_q;
		end else if (mc_tick_q) begin
			irq_req_d = arb_bus.win_valid;
			slot_d = arb_bus.win_slot;
			vec_d = vector_of(arb_bus.win_slot);
			lvl_d = arb_bus.win_level;
		end
		evt_set[3] = wake_d && !wake_q;

		// bus writes
		if (wr) begin
			case (paddr)
				`PIRQ_OFF_EN_A: en_a_d = pwdata[7:0];
				`PIRQ_OFF_EN_B: en_b_d = pwdata[7:0];
				`PIRQ_OFF_PLO_A: plo_a_d = pwdata[7:0];
				`PIRQ_OFF_PHI_A: phi_a_d = pwdata[7:0];
				`PIRQ_OFF_PLO_B: plo_b_d = pwdata[7:0];
				`PIRQ_OFF_PHI_B: phi_b_d = pwdata[7:0];
				`PIRQ_OFF_TRIG: trig_d = pwdata[1:0];
				`PIRQ_OFF_EVT_CLR: evt_st_d = evt_st_q & ~pwdata[3:0];
				`PIRQ_OFF_EVT_EN: evt_en_d = pwdata[3:0];
				default: ;
			endcase
		end
		// a new event wins over a clear in the same cycle
		evt_st_d = evt_st_d | evt_set;
		evt_irq_d = |(evt_st_d & evt_en_d);

		// bus reads, answered with pready
		if (psel && penable && !pready_q) begin
			pslverr_d = !mapped(paddr);
			prdata_d = 32'h0000_0000;
			if (rd) begin
				case (paddr)
					`PIRQ_OFF_EN_A: prdata_d[7:0] = en_a_q;
					`PIRQ_OFF_EN_B: prdata_d[7:0] = en_b_q;
					`PIRQ_OFF_PLO_A: prdata_d[7:0] = plo_a_q;
					`PIRQ_OFF_PHI_A: prdata_d[7:0] = phi_a_q;
					`PIRQ_OFF_PLO_B: prdata_d[7:0] = plo_b_q;
					`PIRQ_OFF_PHI_B: prdata_d[7:0] = phi_b_q;
					`PIRQ_OFF_TRIG: prdata_d[1:0] = trig_q;
					`PIRQ_OFF_STATE: prdata_d = {req_q, 2'b00, slot_q,
						xflag_q, lvl_q, irq_req_q, wake_q, insvc_q};
					`PIRQ_OFF_VECT: prdata_d[15:0] = vec_q;
					`PIRQ_OFF_EVT_ST: prdata_d[3:0] = evt_st_q;
					`PIRQ_OFF_EVT_EN: prdata_d[3:0] = evt_en_q;
					default: prdata_d = 32'h0000_0000;
				endcase
			end
		end else if (!psel) begin
			pslverr_d = 1'b0;
		end
	end

	// arbiter feed
	always_comb begin
		top = top_level(insvc_q);
		arb_bus.req = req_q;
		arb_bus.lvl_hi = {phi_b_q, phi_a_q};
		arb_bus.lvl_lo = {plo_b_q, plo_a_q};
		arb_bus.cur_active = top[2];
		arb_bus.cur_level = top[1:0];
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mc_cnt_q <= 8'h00;
			mc_tick_q <= 1'b0;
			en_a_q <= `PIRQ_REG_RESET;
			en_b_q <= `PIRQ_REG_RESET;
			plo_a_q <= `PIRQ_REG_RESET;
			phi_a_q <= `PIRQ_REG_RESET;
			plo_b_q <= `PIRQ_REG_RESET;
			phi_b_q <= `PIRQ_REG_RESET;
			trig_q <= 2'b00;
			samp_q <= 2'b11;
			xflag_q <= 2'b00;
			req_q <= 16'h0000;
			insvc_q <= 4'h0;
			irq_req_q <= 1'b0;
			slot_q <= 4'h0;
			vec_q <= 16'h0000;
			lvl_q <= 2'b00;
			wake_q <= 1'b0;
			evt_st_q <= 4'h0;
			evt_en_q <= 4'h0;
			evt_irq_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			mc_cnt_q <= mc_cnt_d;
			mc_tick_q <= mc_tick_d;
			en_a_q <= en_a_d;
			en_b_q <= en_b_d;
			plo_a_q <= plo_a_d;
			phi_a_q <= phi_a_d;
			plo_b_q <= plo_b_d;
			phi_b_q <= phi_b_d;
			trig_q <= trig_d;
			samp_q <= samp_d;
			xflag_q <= xflag_d;
			req_q <= req_d;
			insvc_q <= insvc_d;
			irq_req_q <= irq_req_d;
			slot_q <= slot_d;
			vec_q <= vec_d;
			lvl_q <= lvl_d;
			wake_q <= wake_d;
			evt_st_q <= evt_st_d;
			evt_en_q <= evt_en_d;
			evt_irq_q <= evt_irq_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq_req = irq_req_q;
	assign irq_vector = vec_q;
	assign irq_level = lvl_q;
	assign wake = wake_q;
	assign ext0_request_flag = xflag_q[0];
	assign ext1_request_flag = xflag_q[1];
	assign evt_irq = evt_irq_q;
endmodule : pirq_ctrl
`default_nettype wire

// File: pirq_core_model.sv
// Purpose: core model that takes presented vectors
// Assumes: ack is a one-cycle pulse
// Notes: dly sets how slowly the core answers
`timescale 1ns/10ps
`default_nettype none
module pirq_core_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	input wire logic go,
	input wire logic [3:0] dly,
	output logic core_ack,
	output logic [15:0] last_vec,
	output int n_acks
);
	logic [3:0] wait_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			core_ack <= 1'b0;
			wait_q <= 4'h0;
			last_vec <= 16'h0000;
			n_acks <= 0;
		end else begin
			core_ack <= 1'b0;
			// only a take with the request still up counts
			if (core_ack && irq_req) begin
				last_vec <= irq_vector;
				n_acks <= n_acks + 1;
			end
			if (!go || !irq_req || core_ack) begin
				wait_q <= 4'h0;
			end else if (wait_q >= dly) begin
				core_ack <= 1'b1;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule : pirq_core_model
`default_nettype wire

// File: pirq_ctrl_checker.sv
// Purpose: port checks for pirq_ctrl
// Assumes: core pulses ack and return for one cycle
// Notes: svc_q mirrors the levels in service
`timescale 1ns/10ps
`include "pirq_consts.svh"
`default_nettype none
module pirq_ctrl_checker #(
	parameter int MC_CLOCKS = 6
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic core_ack,
	input wire logic core_reti,
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	input wire logic [1:0] irq_level
);
	logic [3:0] svc_q;
	logic [3:0] svc_d;
	logic [1:0] top;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	always_comb begin
		svc_d = svc_q;
		top = 2'h0;
		for (int i = 0; i < 4; i++) begin
			if (svc_q[i]) top = 2'(i);
		end
		// a return in the same cycle as a take pops first
		if (core_reti) svc_d[top] = 1'b0;
		if (core_ack && irq_req) svc_d[irq_level] = 1'b1;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) svc_q <= 4'h0;
		else svc_q <= svc_d;
	end
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	sequence s_end;
		psel && penable && pready;
	endsequence
	sequence s_take;
		core_ack && irq_req;
	endsequence
	property p_lat;
		s_acc |=> pready;
	endproperty
	a_lat: assert property (p_lat) else $error("late pready");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("long pready");
	property p_bad;
		s_end ##0 (paddr > `PIRQ_OFF_EVT_EN || paddr[1:0] != 2'h0)
			|-> pslverr;
	endproperty
	a_bad: assert property (p_bad) else $error("no slave error");
	property p_good;
		s_end ##0 (paddr <= `PIRQ_OFF_EVT_EN && paddr[1:0] == 2'h0)
			|-> !pslverr;
	endproperty
	a_good: assert property (p_good) else $error("false slave error");
	property p_drop;
		s_take |=> !irq_req;
	endproperty
	a_drop: assert property (p_drop) else $error("request kept");
	property p_vec;
		irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0073;
	endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_pre;
		irq_req && svc_q != 4'h0 |-> irq_level > top;
	endproperty
	a_pre: assert property (p_pre) else $error("weak preempt");
	property p_top;
		svc_q[3] |-> !irq_req;
	endproperty
	a_top: assert property (p_top) else $error("top level broken");
endmodule : pirq_ctrl_checker
bind pirq_ctrl pirq_ctrl_checker #(.MC_CLOCKS(MC_CLOCKS)) i_chk (
	.clock(clock), .rst(rst), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr),
	.core_ack(core_ack), .core_reti(core_reti), .irq_req(irq_req),
	.irq_vector(irq_vector), .irq_level(irq_level)
);
`default_nettype wire

// File: pirq_ctrl_tb_top.sv
// Purpose: self-checking bench for pirq_ctrl
// Assumes: machine cycle shortened to two clocks
// Notes: src bits stand for the request inputs
`timescale 1ns/10ps
`default_nettype none
module pirq_ctrl_tb_top;
	logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, core_reti = 1'b0, go = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [16:0] src = 17'h0_0000;
	logic [3:0] dly = 4'h0;
	logic [31:0] prdata;
	logic [15:0] irq_vector, last_vec;
	logic [1:0] irq_level;
	logic pready, pslverr, core_ack, irq_req, wake, fl0, fl1, evt_irq;
	int n_acks, n_errors = 0, n_tests = 0;
	int rk[13] = '{0, 6, 7, 1, 8, 14, 2, 12, 15, 3, 13, 4, 16};
	logic [15:0] rv[13] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B,
		16'h0033, 16'h005B, 16'h0013, 16'h003B, 16'h0063, 16'h001B,
		16'h0043, 16'h0023, 16'h0073};
	int sh[6] = '{4, 5, 8, 9, 10, 11};
	always #25 clock = ~clock;
	pirq_ctrl #(.MC_CLOCKS(2)) i_pirq_ctrl (
		.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext0_pin_n(~src[0]),
		.ext1_pin_n(~src[2]), .timer_zero_overflow_flag(src[1]),
		.timer_one_overflow_flag(src[3]), .serial_tx_done_flag(src[4]),
		.serial_rx_done_flag(src[5]), .brownout_flag(src[6]),
		.watchdog_overflow_flag(src[7]), .bus_data_ready_flag(src[8]),
		.bus_arb_loss_flag(src[9]), .bus_start_flag(src[10]),
		.bus_stop_flag(src[11]), .keypad_flag(src[12]),
		.comparator_two_flag(src[13]), .converter_done_flag(src[14]),
		.comparator_one_flag(src[15]), .bus_timeout_flag(src[16]),
		.core_ack(core_ack), .core_reti(core_reti), .irq_req(irq_req),
		.irq_vector(irq_vector), .irq_level(irq_level), .wake(wake),
		.ext0_request_flag(fl0), .ext1_request_flag(fl1),
		.evt_irq(evt_irq)
	);
	pirq_core_model i_pirq_core_model (
		.clock(clock), .rst(rst), .irq_req(irq_req),
		.irq_vector(irq_vector), .go(go), .dly(dly), .core_ack(core_ack),
		.last_vec(last_vec), .n_acks(n_acks)
	);
	// ----
	// tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] x);
		n_tests++;
		if (got !== x) begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		if (n == 20) n_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
		chk(32'(e), 32'(xe));
	endtask : rd
	task automatic want(input logic [15:0] v, input logic [1:0] l);
		int n;
		int k;
		n = 0;
		k = n_acks;
		while (irq_req !== 1'b1 && n < 40) begin
			@(posedge clock);
			n++;
		end
		chk(32'(irq_vector), 32'(v));
		chk(32'(irq_level), 32'(l));
		go <= 1'b1;
		while (n_acks == k && n < 80) begin
			@(posedge clock);
			n++;
		end
		go <= 1'b0;
		chk(32'(last_vec), 32'(v));
		chk(32'(n_acks), 32'(k + 1));
	endtask : want
	task automatic none();
		logic seen;
		seen = 1'b0;
		repeat (12) begin
			@(posedge clock);
			seen = seen | irq_req;
		end
		chk(32'(seen), 32'h0);
	endtask : none
	// waits out pin sync and a tick so a dropped level source is gone
	task automatic back();
		repeat (8) @(posedge clock);
		core_reti <= 1'b1;
		@(posedge clock);
		core_reti <= 1'b0;
	endtask : back
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	// ----
	// tests
	// ----
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(8'h00, 32'h0000_0000, 1'b0);
		rd(8'h30, 32'h0000_0000, 1'b1);
		rd(8'h02, 32'h0000_0000, 1'b1);
		wr(8'h08, 32'hFFFF_FF3A);
		rd(8'h08, 32'h0000_003A, 1'b0);
		wr(8'h08, 32'h0000_0000);
		src <= 17'h0_0005;
		repeat (8) @(posedge clock);
		chk(32'(fl0), 32'h1);
		chk(32'(fl1), 32'h1);
		src <= 17'h0_0000;
		repeat (8) @(posedge clock);
		chk(32'(fl0), 32'h0);
		chk(32'(fl1), 32'h0);
		wr(8'h00, 32'h0000_007F);
		wr(8'h04, 32'h0000_0002);
		src <= 17'h0_1002;
		none();
		chk(32'(wake), 32'h0);
		wr(8'h00, 32'h0000_0080);
		want(16'h003B, 2'h0);
		chk(32'(wake), 32'h1);
		rd(8'h1C, 32'h0200_2411, 1'b0);
		src <= 17'h0_0002;
		back();
		none();
		wr(8'h00, 32'h0000_0082);
		want(16'h000B, 2'h0);
		chk(32'(wake), 32'h0);
		src <= 17'h0_0000;
		back();
		wr(8'h00, 32'h0000_0090);
		wr(8'h04, 32'h0000_0001);
		foreach (sh[i]) begin
			src <= 17'h0_0001 << sh[i];
			want(sh[i] < 8 ? 16'h0023 : 16'h0033, 2'h0);
			src <= 17'h0_0000;
			back();
		end
		// hold off until the pin request is sampled with the rest
		wr(8'h00, 32'h0000_007F);
		wr(8'h04, 32'h0000_00B7);
		src <= 17'h1_F1DF;
		repeat (10) @(posedge clock);
		wr(8'h00, 32'h0000_00FF);
		for (int k = 0; k < 13; k++) begin
			dly <= k[0] ? 4'h5 : 4'h0;
			want(rv[k], 2'h0);
			src[rk[k]] <= 1'b0;
			back();
		end
		wr(8'h08, 32'h0000_004A);
		wr(8'h0C, 32'h0000_0062);
		src <= 17'h0_0042;
		want(16'h000B, 2'h3);
		src <= 17'h0_00C0;
		none();
		src <= 17'h0_0000;
		back();
		src <= 17'h0_0008;
		want(16'h001B, 2'h1);
		src <= 17'h0_0009;
		none();
		src <= 17'h0_0049;
		want(16'h002B, 2'h2);
		src <= 17'h0_0001;
		back();
		none();
		back();
		want(16'h0003, 2'h0);
		src <= 17'h0_0000;
		back();
		wr(8'h28, 32'h0000_000F);
		wr(8'h2C, 32'h0000_0001);
		wr(8'h18, 32'h0000_0001);
		wr(8'h00, 32'h0000_0081);
		src <= 17'h0_0001;
		repeat (8) @(posedge clock);
		src <= 17'h0_0000;
		repeat (8) @(posedge clock);
		chk(32'(fl0), 32'h1);
		want(16'h0003, 2'h0);
		repeat (2) @(posedge clock);
		chk(32'(fl0), 32'h0);
		chk(32'(evt_irq), 32'h1);
		rd(8'h24, 32'h0000_0009, 1'b0);
		wr(8'h28, 32'h0000_0001);
		chk(32'(evt_irq), 32'h0);
		back();
		chk(32'(evt_irq), 32'h0);
		rd(8'h24, 32'h0000_000A, 1'b0);
		give_verdict();
	end
endmodule : pirq_ctrl_tb_top
`default_nettype wire
